/* File: include/fmt_decode_pkg.sv */
// Constants for the format command field decoder
package fmt_decode_pkg;
    // Field positions within the low command word
    localparam int PROT_MSB = 7;
    localparam int PROT_LSB = 5;
    localparam int INLINE_BIT = 4;
    localparam int INDEX_MSB = 3;
    localparam int INDEX_LSB = 0;
    // Protection type encodings
    localparam logic [2:0] PROT_NONE = 3'h0;
    localparam logic [2:0] PROT_TYPE1 = 3'h1;
    localparam logic [2:0] PROT_TYPE2 = 3'h2;
    localparam logic [2:0] PROT_TYPE3 = 3'h3;
    // Completion status codes
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_INVALID_FORMAT = 8'h0a;
    // Protection information size in bytes
    localparam logic [15:0] PROT_INFO_BYTES = 16'h0008;
    // Reset values
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [2:0] PROT_RESET = 3'h0;
endpackage

/* File: verilog/format_command_field_decode.sv */
// Decoder for the low byte of the media format command word
`timescale 1ns/1ps
module format_command_field_decode
    import fmt_decode_pkg::*;
#(
    parameter int NUM_FORMATS = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_word,
    input wire logic [15:0] fmt_valid_mask,
    input wire logic [15:0] fmt_meta_bytes,
    output logic done_reg,
    output logic [7:0] status_reg,
    output logic [3:0] block_format_index_reg,
    output logic [2:0] protection_type_sel_reg,
    output logic metadata_inline_sel_reg,
    output logic metadata_separate_reg,
    output logic prot_in_meta_reg
);
    // Elaboration check: the mask and the index field cover sixteen formats at most
    if (NUM_FORMATS < 1 || NUM_FORMATS > 16) begin : g_bad_num_formats
        $error("NUM_FORMATS must be 1 to 16");
    end

    // Fields of the command byte
    logic [2:0] prot_field;
    logic inline_field;
    logic [3:0] index_field;
    // Per-format and per-command checks
    logic [15:0] format_usable;
    logic meta_present;
    logic bad_index;
    logic bad_prot;
    logic short_meta;
    logic reject;
    logic apply_cmd;
    // Next values of the completion group
    logic done_next;
    logic [7:0] status_next;
    // Next values of the applied format group
    logic [3:0] index_next;
    logic [2:0] prot_next;
    logic inline_next;
    logic separate_next;
    logic pim_next;

    // Field extraction; the higher bits of the command word are decoded elsewhere
    assign prot_field = cmd_word[PROT_MSB:PROT_LSB];
    assign inline_field = cmd_word[INLINE_BIT];
    assign index_field = cmd_word[INDEX_MSB:INDEX_LSB];

    // A format is usable only if it lies inside the table and is reported valid
    for (genvar n = 0; n < 16; n++) begin : g_format_usable
        if (n < NUM_FORMATS) begin : g_listed
            assign format_usable[n] = fmt_valid_mask[n];
        end else begin : g_unlisted
            // Mask bits past the table are ignored, so a stray one cannot select them
            assign format_usable[n] = 1'b0;
        end
    end

    // Refusal conditions; any one of them blocks the format change
    assign bad_index = !format_usable[index_field];
    assign bad_prot = prot_field > PROT_TYPE3;
    // Protection needs room for its eight bytes in the metadata
    assign short_meta = (prot_field != PROT_NONE) && (fmt_meta_bytes < PROT_INFO_BYTES);
    assign reject = bad_index || bad_prot || short_meta;
    assign apply_cmd = cmd_valid && !reject;
    // A zero metadata size makes the placement bit meaningless
    assign meta_present = fmt_meta_bytes != 16'h0000;

    // Completion: every command is answered one cycle later, refused or not
    always_comb begin
        done_next = cmd_valid;
        status_next = status_reg;
        if (cmd_valid) begin
            if (reject) begin
                status_next = STATUS_INVALID_FORMAT;
            end else begin
                status_next = STATUS_OK;
            end
        end
    end

    // Applied format: a refused command leaves every field as it was
    always_comb begin
        index_next = block_format_index_reg;
        prot_next = protection_type_sel_reg;
        inline_next = metadata_inline_sel_reg;
        separate_next = metadata_separate_reg;
        pim_next = prot_in_meta_reg;
        if (apply_cmd) begin
            index_next = index_field;
            prot_next = prot_field;
            // No metadata means neither placement applies
            inline_next = meta_present && inline_field;
            separate_next = meta_present && !inline_field;
            // Protection rides in whichever metadata area was chosen
            pim_next = prot_field != PROT_NONE;
        end
    end

    // Completion registers; status holds until the next command arrives
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
            status_reg <= STATUS_OK;
        end else begin
            done_reg <= done_next;
            status_reg <= status_next;
        end
    end

    // Applied format registers; after reset no protection and no placement is chosen
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            block_format_index_reg <= INDEX_RESET;
            protection_type_sel_reg <= PROT_RESET;
            metadata_inline_sel_reg <= 1'b0;
            metadata_separate_reg <= 1'b0;
            prot_in_meta_reg <= 1'b0;
        end else begin
            block_format_index_reg <= index_next;
            protection_type_sel_reg <= prot_next;
            metadata_inline_sel_reg <= inline_next;
            metadata_separate_reg <= separate_next;
            prot_in_meta_reg <= pim_next;
        end
    end

    // Checks on the completion group
    // Every command gets its answer on the next edge
    a_done_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid |=> done_reg)
        else $error("command not completed");
    // No answer appears without a command behind it
    a_done_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cmd_valid |=> !done_reg)
        else $error("completion without a command");
    // Status stands between commands
    a_status_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cmd_valid |=> $stable(status_reg))
        else $error("status changed without a command");
    // A usable format without protection is always taken
    a_status_ok: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && fmt_valid_mask[cmd_word[INDEX_MSB:INDEX_LSB]]
        && 32'(cmd_word[INDEX_MSB:INDEX_LSB]) < NUM_FORMATS
        && cmd_word[PROT_MSB:PROT_LSB] == PROT_NONE
        |=> status_reg == STATUS_OK)
        else $error("usable format refused");
    // A format not reported valid is refused and not applied
    a_invalid_status: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !fmt_valid_mask[cmd_word[INDEX_MSB:INDEX_LSB]]
        |=> done_reg && status_reg == STATUS_INVALID_FORMAT
            && $stable(block_format_index_reg))
        else $error("bad index not refused");
    // Protection without eight metadata bytes is refused
    a_short_meta: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && cmd_word[PROT_MSB:PROT_LSB] != PROT_NONE
        && fmt_meta_bytes < PROT_INFO_BYTES
        |=> status_reg == STATUS_INVALID_FORMAT && $stable(protection_type_sel_reg)
            && $stable(prot_in_meta_reg))
        else $error("protection without room accepted");
    // A reserved type is refused and the format kept
    a_reserved_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && cmd_word[PROT_MSB:PROT_LSB] > PROT_TYPE3
        |=> status_reg == STATUS_INVALID_FORMAT && $stable(protection_type_sel_reg)
            && $stable(block_format_index_reg))
        else $error("reserved type changed format");

    // Checks on the applied format group
    // An accepted type lands one edge after the command
    a_prot_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !reject
        |=> protection_type_sel_reg == $past(cmd_word[PROT_MSB:PROT_LSB]))
        else $error("protection type not applied");
    // The applied type never holds a reserved code
    a_type_range: assert property (@(posedge core_clk) disable iff (!rst_b)
        protection_type_sel_reg <= PROT_TYPE3)
        else $error("reserved protection type applied");
    // Inline placement follows the bit when metadata exists
    a_inline_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !reject && cmd_word[INLINE_BIT] && fmt_meta_bytes != 16'h0000
        |=> metadata_inline_sel_reg)
        else $error("inline placement not set");
    // Separate placement follows the cleared bit when metadata exists
    a_separate_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !reject && !cmd_word[INLINE_BIT] && fmt_meta_bytes != 16'h0000
        |=> metadata_separate_reg && !metadata_inline_sel_reg)
        else $error("separate placement not set");
    // The two placements exclude each other
    a_placement_excl: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(metadata_inline_sel_reg && metadata_separate_reg))
        else $error("both metadata placements chosen");
    // Protection in metadata needs a chosen metadata area
    a_prot_in_meta: assert property (@(posedge core_clk) disable iff (!rst_b)
        (prot_in_meta_reg == (protection_type_sel_reg != PROT_NONE))
        && (!prot_in_meta_reg || metadata_inline_sel_reg || metadata_separate_reg))
        else $error("protection placement mismatch");
    // Without metadata the placement bit has no effect
    a_zero_meta: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !reject && fmt_meta_bytes == 16'h0000
        |=> !metadata_inline_sel_reg && !metadata_separate_reg)
        else $error("placement used without metadata");
    // An accepted index lands together with the answer
    a_index_apply: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !reject
        |=> block_format_index_reg == $past(cmd_word[INDEX_MSB:INDEX_LSB]) && done_reg)
        else $error("format index not applied");
endmodule

/* File: verif/host_model.sv */
// Host model that issues format commands
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_word,
    output logic [15:0] fmt_valid_mask,
    output logic [15:0] fmt_meta_bytes
);
    // Idle host, all reported formats valid
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 8'h00;
        fmt_valid_mask = 16'hffff;
        fmt_meta_bytes = 16'h0000;
    end
    // One-cycle pulse off the falling edge; the mask stays level
    task automatic issue(input logic [7:0] w, input logic [15:0] m, input logic [15:0] b);
        @(negedge core_clk);
        cmd_word = w;
        fmt_valid_mask = m;
        fmt_meta_bytes = b;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the format field decoder
`timescale 1ns/1ps
module tb_top;
    import fmt_decode_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid, done_reg, inl, sep, pim;
    logic [7:0] cmd_word, status_reg;
    logic [15:0] mask, meta;
    logic [3:0] idx;
    logic [2:0] prot;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    initial forever #25 core_clk = ~core_clk;
    host_model u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .fmt_valid_mask(mask), .fmt_meta_bytes(meta));
    format_command_field_decode u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .fmt_valid_mask(mask),
        .fmt_meta_bytes(meta), .done_reg(done_reg), .status_reg(status_reg),
        .block_format_index_reg(idx), .protection_type_sel_reg(prot),
        .metadata_inline_sel_reg(inl), .metadata_separate_reg(sep), .prot_in_meta_reg(pim));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Expected state packs index, type, inline, separate, carried-in-metadata
    task automatic run(input logic [7:0] w, input logic [15:0] m, input logic [15:0] b,
        input logic [7:0] st, input logic [9:0] f);
        u_host.issue(w, m, b);
        chk("done", 32'h1, {31'h0, done_reg});
        chk("status", {24'h0, st}, {24'h0, status_reg});
        chk("format", {22'h0, f}, {22'h0, idx, prot, inl, sep, pim});
        @(negedge core_clk);
        chk("done low", 32'h0, {31'h0, done_reg});
        chk("status held", {24'h0, st}, {24'h0, status_reg});
    endtask
    task automatic t_accept();
        run(8'h31, 16'h0002, 16'h0008, STATUS_OK, {4'h1, PROT_TYPE1, 3'b101});
        run(8'h45, 16'h0020, 16'h0010, STATUS_OK, {4'h5, PROT_TYPE2, 3'b011});
        run(8'h7f, 16'h8000, 16'h0008, STATUS_OK, {4'hf, PROT_TYPE3, 3'b101});
        run(8'h12, 16'h0004, 16'h0000, STATUS_OK, {4'h2, PROT_NONE, 3'b000});
        $display("accept test done");
    endtask
    // Refused commands must leave the applied format alone
    task automatic t_refuse();
        for (int p = 4; p < 8; p++)
            run({p[2:0], 5'h13}, 16'hffff, 16'h0008, STATUS_INVALID_FORMAT, 10'h080);
        run(8'h23, 16'hfff7, 16'h0008, STATUS_INVALID_FORMAT, 10'h080);
        run(8'h23, 16'hffff, 16'h0004, STATUS_INVALID_FORMAT, 10'h080);
        run(8'h31, 16'h0002, 16'h0008, STATUS_OK, {4'h1, PROT_TYPE1, 3'b101});
        $display("refuse test done");
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        chk("reset", 32'h0, {13'h0, done_reg, status_reg, idx, prot, inl, sep, pim});
        t_accept();
        t_refuse();
        report_and_stop();
    end
endmodule
